// ---- rtl/sccr_pkg.sv ----
/*
 secondary command register package: offsets, field positions, reset
 values and small shared types.
 assumes a 32-bit apb register bus on one clock.
*/
package sccr_pkg;
    localparam logic [11:0] SCCR_CMD_OFF = 12'h044;
    localparam logic [11:0] SCCR_IRQ_STAT_OFF = 12'h100;
    localparam logic [11:0] SCCR_IRQ_MASK_OFF = 12'h104;
    localparam logic [11:0] SCCR_MODE_OFF = 12'h108;
    localparam int SCCR_IO_BIT = 0;
    localparam int SCCR_MEM_BIT = 1;
    localparam int SCCR_BM_BIT = 2;
    localparam int SCCR_PERR_BIT = 6;
    localparam int SCCR_SERR_BIT = 8;
    localparam int SCCR_INTD_BIT = 10;
    localparam logic [15:0] SCCR_CMD_RW_MASK = 16'h0547;
    localparam logic [15:0] SCCR_CMD_RESET = 16'h0000;
    localparam logic [3:0] SCCR_IRQ_RESET = 4'h0;
    localparam int SCCR_IRQ_PERR = 0;
    localparam int SCCR_IRQ_ERRMSG = 1;
    localparam int SCCR_IRQ_SERR = 2;
    localparam int SCCR_IRQ_INTX = 3;
    typedef enum logic [1:0] {
        SCCR_SETUP,
        SCCR_ACCESS
    } sccr_phase_t;
endpackage

// ---- rtl/sccr_sync.sv ----
/*
 two flip-flop synchroniser for one level.
 assumes the input is asynchronous to pclk.
*/
`timescale 1ns/100ps
module sccr_sync (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // level
    input wire logic d,
    output logic q
);
    typedef struct packed {
        logic s1;
        logic s2;
    } sccr_sync_t;
    sccr_sync_t st_r, st_nxt;
    always_comb begin
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign q = st_r.s2;
endmodule

// ---- rtl/sccr_gate.sv ----
/*
 transaction gating: decides which secondary-side actions the command
 bits allow.
 assumes request inputs come from logic on pclk.
*/
`timescale 1ns/100ps
module sccr_gate
    import sccr_pkg::*;
(
    // command and mode
    input wire logic [15:0] cmd,
    input wire logic reverse_mode,
    input wire logic pcix_mode,
    // requests
    input wire logic io_req,
    input wire logic mem_rd_req,
    input wire logic mem_wr_req,
    input wire logic mst_req,
    input wire logic split_cpl_req,
    input wire logic special_req,
    input wire logic snoop_req,
    input wire logic mwi_own_req,
    // grants
    output logic io_accept,
    output logic mem_rd_accept,
    output logic mem_wr_accept,
    output logic mst_grant,
    output logic split_cpl_grant,
    output logic ignored
);
    logic bm;
    always_comb begin
        bm = cmd[SCCR_BM_BIT];
        io_accept = io_req && cmd[SCCR_IO_BIT] && bm;
        mem_rd_accept = mem_rd_req && cmd[SCCR_MEM_BIT] && bm;
        mem_wr_accept = mem_wr_req && bm;
        // own mwi never originated
        mst_grant = mst_req && bm && !mwi_own_req;
        // split completions free in reverse pci-x
        split_cpl_grant = split_cpl_req && (bm || (reverse_mode && pcix_mode));
        // special cycles and palette snoops never claimed
        ignored = special_req || snoop_req ||
            (io_req && !io_accept) || (mem_rd_req && !mem_rd_accept);
    end
endmodule

// ---- rtl/sccr_top.sv ----
/*
 secondary-side command register with apb slave, transaction gating,
 error reporting gates and a sticky interrupt status.
 assumes apb master on pclk; error events from logic on pclk;
 the bridge mode straps arrive asynchronously from pins.
*/
`timescale 1ns/100ps
module sccr_top
    import sccr_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // mode straps from pins
    input wire logic reverse_pin,
    input wire logic pcix_pin,
    // secondary requests
    input wire logic io_req,
    input wire logic mem_rd_req,
    input wire logic mem_wr_req,
    input wire logic mst_req,
    input wire logic split_cpl_req,
    input wire logic special_req,
    input wire logic snoop_req,
    input wire logic mwi_own_req,
    // grants
    output logic io_accept,
    output logic mem_rd_accept,
    output logic mem_wr_accept,
    output logic mst_grant,
    output logic split_cpl_grant,
    output logic ignored,
    // error events
    input wire logic parity_event,
    input wire logic error_event,
    input wire logic intx_req,
    // error and interrupt outputs
    output logic mdpe_set,
    output logic err_msg_send,
    output logic serr_n_o,
    output logic serr_n_oe,
    output logic intx_assert,
    output logic irq
);
    import sccr_pkg::*;

    typedef struct packed {
        logic [15:0] cmd;
        logic [3:0] stat;
        logic [3:0] mask;
        logic mdpe;
        logic err_msg;
        logic serr_drv;
        logic intx;
        logic [31:0] rdata;
    } sccr_state_t;

    sccr_state_t st_r, st_nxt;
    logic reverse_mode;
    logic pcix_mode;
    logic wr_en;
    logic rd_en;
    logic rd_setup;
    logic hit;
    logic [3:0] ev;

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic known(input logic [11:0] a);
        return a == SCCR_CMD_OFF || a == SCCR_IRQ_STAT_OFF ||
            a == SCCR_IRQ_MASK_OFF || a == SCCR_MODE_OFF;
    endfunction

    sccr_sync u_rev_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(reverse_pin),
        .q(reverse_mode)
    );

    sccr_sync u_pcix_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(pcix_pin),
        .q(pcix_mode)
    );

    sccr_gate u_gate (
        .cmd(st_r.cmd),
        .reverse_mode(reverse_mode),
        .pcix_mode(pcix_mode),
        .io_req(io_req),
        .mem_rd_req(mem_rd_req),
        .mem_wr_req(mem_wr_req),
        .mst_req(mst_req),
        .split_cpl_req(split_cpl_req),
        .special_req(special_req),
        .snoop_req(snoop_req),
        .mwi_own_req(mwi_own_req),
        .io_accept(io_accept),
        .mem_rd_accept(mem_rd_accept),
        .mem_wr_accept(mem_wr_accept),
        .mst_grant(mst_grant),
        .split_cpl_grant(split_cpl_grant),
        .ignored(ignored)
    );

    assign hit = known(paddr);
    assign wr_en = psel && penable && pwrite && hit;
    assign rd_en = psel && penable && !pwrite && hit;
    assign rd_setup = psel && !penable && !pwrite && hit;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    always_comb begin
        logic [31:0] m;
        m = '0;
        st_nxt = st_r;
        ev = '0;
        // parity flag only when response enabled
        ev[SCCR_IRQ_PERR] = parity_event && st_r.cmd[SCCR_PERR_BIT];
        // forward error message gate
        ev[SCCR_IRQ_ERRMSG] = error_event && !reverse_mode &&
            st_r.cmd[SCCR_SERR_BIT];
        // reverse serr gate
        ev[SCCR_IRQ_SERR] = error_event && reverse_mode &&
            st_r.cmd[SCCR_SERR_BIT];
        // intx while not disabled
        ev[SCCR_IRQ_INTX] = intx_req && !st_r.cmd[SCCR_INTD_BIT];
        st_nxt.mdpe = ev[SCCR_IRQ_PERR];
        st_nxt.err_msg = ev[SCCR_IRQ_ERRMSG];
        st_nxt.serr_drv = ev[SCCR_IRQ_SERR];
        st_nxt.intx = ev[SCCR_IRQ_INTX];
        if (wr_en) begin
            case (paddr)
                SCCR_CMD_OFF: begin
                    m = merge({16'h0000, st_r.cmd}, pwdata, pstrb);
                    // ro and reserved bits dropped
                    st_nxt.cmd = m[15:0] & SCCR_CMD_RW_MASK;
                end
                SCCR_IRQ_MASK_OFF: begin
                    if (pstrb[0]) begin
                        st_nxt.mask = pwdata[3:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // read data loaded in setup so it stands through the access
        if (rd_setup) begin
            case (paddr)
                SCCR_CMD_OFF: st_nxt.rdata = {16'h0000, st_r.cmd};
                SCCR_IRQ_STAT_OFF:
                    st_nxt.rdata = {28'h0000000, st_r.stat | ev};
                SCCR_IRQ_MASK_OFF: st_nxt.rdata = {28'h0000000, st_r.mask};
                SCCR_MODE_OFF:
                    st_nxt.rdata = {30'h00000000, pcix_mode, reverse_mode};
                default: st_nxt.rdata = '0;
            endcase
        end
        // read clears, new events win
        if (rd_en && paddr == SCCR_IRQ_STAT_OFF) begin
            st_nxt.stat = ev;
        end else begin
            st_nxt.stat = st_r.stat | ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r.cmd <= SCCR_CMD_RESET;
            st_r.stat <= SCCR_IRQ_RESET;
            st_r.mask <= SCCR_IRQ_RESET;
            st_r.mdpe <= 1'b0;
            st_r.err_msg <= 1'b0;
            st_r.serr_drv <= 1'b0;
            st_r.intx <= 1'b0;
            st_r.rdata <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.rdata;
    assign mdpe_set = st_r.mdpe;
    assign err_msg_send = st_r.err_msg;
    // open-drain serr: drive low only when enabled
    assign serr_n_o = 1'b0;
    assign serr_n_oe = st_r.serr_drv;
    // released at once when disabled
    assign intx_assert = st_r.intx && !st_r.cmd[SCCR_INTD_BIT];
    assign irq = |(st_r.stat & st_r.mask);

    a_cmd_ro_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r.cmd & ~SCCR_CMD_RW_MASK) == 16'h0000)
        else $error("read-only command bit set");
    a_io_gate: assert property (@(posedge pclk) disable iff (!presetn)
        io_accept |-> st_r.cmd[SCCR_IO_BIT] && st_r.cmd[SCCR_BM_BIT])
        else $error("io accepted while disabled");
    a_mem_gate: assert property (@(posedge pclk) disable iff (!presetn)
        mem_rd_req && !st_r.cmd[SCCR_MEM_BIT] |-> !mem_rd_accept && ignored)
        else $error("memory read not ignored");
    a_master_gate: assert property (@(posedge pclk) disable iff (!presetn)
        mst_grant |-> st_r.cmd[SCCR_BM_BIT] && !mwi_own_req)
        else $error("master without enable");
    a_split_free: assert property (@(posedge pclk) disable iff (!presetn)
        split_cpl_req && reverse_mode && pcix_mode |-> split_cpl_grant)
        else $error("split completion blocked");
    a_special_ign: assert property (@(posedge pclk) disable iff (!presetn)
        special_req || snoop_req |-> ignored)
        else $error("special or snoop claimed");
    a_parity_flag: assert property (@(posedge pclk) disable iff (!presetn)
        parity_event && st_r.cmd[SCCR_PERR_BIT] |=> mdpe_set)
        else $error("parity flag missing");
    a_parity_off: assert property (@(posedge pclk) disable iff (!presetn)
        mdpe_set |-> $past(st_r.cmd[SCCR_PERR_BIT]))
        else $error("parity flag while disabled");
    a_errmsg_gate: assert property (@(posedge pclk) disable iff (!presetn)
        err_msg_send |-> $past(st_r.cmd[SCCR_SERR_BIT]) && !$past(reverse_mode))
        else $error("error message without enable");
    a_serr_gate: assert property (@(posedge pclk) disable iff (!presetn)
        serr_n_oe |-> $past(st_r.cmd[SCCR_SERR_BIT]) && $past(reverse_mode))
        else $error("serr driven without enable");
    a_intx_off: assert property (@(posedge pclk) disable iff (!presetn)
        st_r.cmd[SCCR_INTD_BIT] |-> !intx_assert)
        else $error("intx while disabled");
endmodule

// ---- verification/sccr_sec_agent.sv ----
/*
 secondary bus agent model: drives request levels and error events.
 assumes the bench drives rq_set and ev_set; all changes land just after pclk rises.
*/
`timescale 1ns/100ps
module sccr_sec_agent (
    // clock
    input wire logic pclk,
    // levels asked for by the bench
    input wire logic [7:0] rq_set,
    input wire logic [2:0] ev_set,
    // requests and events toward the bridge
    output logic [7:0] rq,
    output logic [2:0] ev
);
    // levels launched just after the edge, held until changed
    always @(posedge pclk) begin
        rq <= rq_set;
        ev <= ev_set;
    end
endmodule

// ---- verification/tb_secondary_command_control.sv ----
/*
 self-checking bench for the secondary command register block.
 assumes sccr_top with zero-wait apb and the agent model beside it.
*/
`timescale 1ns/100ps
module tb_secondary_command_control;
    import sccr_pkg::*;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr;
    logic reverse_pin, pcix_pin;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [7:0] rq, rq_set;
    logic [2:0] ev, ev_set;
    logic [5:0] g, o;
    int n_mismatch = 0, tests_run = 0, cyc = 0;
    sccr_sec_agent u_sccr_sec_agent (
        .pclk(pclk), .rq_set(rq_set), .ev_set(ev_set), .rq(rq), .ev(ev)
    );
    sccr_top u_sccr_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reverse_pin(reverse_pin), .pcix_pin(pcix_pin),
        .io_req(rq[0]), .mem_rd_req(rq[1]), .mem_wr_req(rq[2]),
        .mst_req(rq[3]), .split_cpl_req(rq[4]), .special_req(rq[5]),
        .snoop_req(rq[6]), .mwi_own_req(rq[7]),
        .io_accept(g[0]), .mem_rd_accept(g[1]), .mem_wr_accept(g[2]),
        .mst_grant(g[3]), .split_cpl_grant(g[4]), .ignored(g[5]),
        .parity_event(ev[0]), .error_event(ev[1]), .intx_req(ev[2]),
        .mdpe_set(o[0]), .err_msg_send(o[1]), .serr_n_o(o[2]),
        .serr_n_oe(o[3]), .intx_assert(o[4]), .irq(o[5])
    );
    always #2 pclk = ~pclk;
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            end_of_test;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d, input logic [3:0] s,
            output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        err = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wrs(input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, s, r, e);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        wrs(a, d, 4'hF);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, 4'h0, r, e);
        check(r, x);
    endtask
    task automatic req(input logic [7:0] r);
        @(posedge pclk);
        rq_set <= r;
        @(posedge pclk);
    endtask
    task automatic evt(input logic [2:0] e);
        @(posedge pclk);
        ev_set <= e;
        @(posedge pclk);
    endtask
    task automatic gc(input logic [7:0] r, input logic [5:0] m,
            input logic [5:0] x);
        req(r);
        #1;
        check({26'h0, g & m}, {26'h0, x});
    endtask
    task automatic evc(input logic [2:0] e, input logic [5:0] m,
            input logic [5:0] x);
        evt(e);
        @(posedge pclk);
        #1;
        check({26'h0, o & m}, {26'h0, x});
    endtask
    task automatic mode(input logic r, input logic x);
        @(posedge pclk);
        reverse_pin <= r;
        pcix_pin <= x;
        repeat (3) @(posedge pclk);
        #1;
    endtask
    task automatic t_reset;
        check({20'h0, g, o}, 32'h0);
        rdc(SCCR_CMD_OFF, 32'h0);
        rdc(SCCR_IRQ_STAT_OFF, 32'h0);
        rdc(SCCR_IRQ_MASK_OFF, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_bits;
        logic [31:0] r;
        logic e;
        wr(SCCR_CMD_OFF, 32'hFFFF_FFFF);
        rdc(SCCR_CMD_OFF, 32'h547);
        wr(SCCR_CMD_OFF, 32'h0);
        rdc(SCCR_CMD_OFF, 32'h0);
        wrs(SCCR_CMD_OFF, 32'hFFFF_FFFF, 4'h1);
        rdc(SCCR_CMD_OFF, 32'h47);
        wrs(SCCR_IRQ_MASK_OFF, 32'hF, 4'hE);
        rdc(SCCR_IRQ_MASK_OFF, 32'h0);
        wr(SCCR_CMD_OFF, 32'h0);
        apb(1'b1, 12'h200, 32'hFFFF_FFFF, 4'hF, r, e);
        check({31'h0, e}, 32'h1);
        rdc(SCCR_CMD_OFF, 32'h0);
        $display("bits test done");
    endtask
    task automatic t_gate;
        logic [15:0] c [6] = '{16'h0, 16'h1, 16'h3, 16'h4, 16'h5, 16'h6};
        logic [5:0] x [6] = '{6'h00, 6'h00, 6'h00, 6'h0C, 6'h0D, 6'h0E};
        for (int i = 0; i < 6; i++) begin
            wr(SCCR_CMD_OFF, {16'h0, c[i]});
            gc(8'h0F, 6'h0F, x[i]);
        end
        wr(SCCR_CMD_OFF, 32'h7);
        gc(8'h60, 6'h3F, 6'h20);
        gc(8'h88, 6'h08, 6'h00);
        gc(8'h08, 6'h08, 6'h08);
        req(8'h00);
        $display("gate test done");
    endtask
    task automatic t_split;
        mode(1'b1, 1'b1);
        rdc(SCCR_MODE_OFF, 32'h3);
        wr(SCCR_CMD_OFF, 32'h0);
        gc(8'h10, 6'h10, 6'h10);
        mode(1'b1, 1'b0);
        gc(8'h10, 6'h10, 6'h00);
        req(8'h00);
        mode(1'b0, 1'b0);
        $display("split test done");
    endtask
    task automatic t_events;
        wr(SCCR_IRQ_MASK_OFF, 32'hF);
        evc(3'b001, 6'h01, 6'h00);
        wr(SCCR_CMD_OFF, 32'h40);
        evc(3'b001, 6'h21, 6'h21);
        evt(3'b000);
        rdc(SCCR_IRQ_STAT_OFF, 32'h1);
        #1;
        check({31'h0, o[5]}, 32'h0);
        wr(SCCR_IRQ_MASK_OFF, 32'h0);
        evc(3'b001, 6'h20, 6'h00);
        evt(3'b000);
        rdc(SCCR_IRQ_STAT_OFF, 32'h1);
        wr(SCCR_CMD_OFF, 32'h100);
        evc(3'b010, 6'h0A, 6'h02);
        wr(SCCR_CMD_OFF, 32'h0);
        evc(3'b010, 6'h0A, 6'h00);
        evt(3'b000);
        mode(1'b1, 1'b0);
        wr(SCCR_CMD_OFF, 32'h100);
        evc(3'b010, 6'h0E, 6'h08);
        wr(SCCR_CMD_OFF, 32'h0);
        evc(3'b010, 6'h0A, 6'h00);
        evt(3'b000);
        mode(1'b0, 1'b0);
        evc(3'b100, 6'h10, 6'h10);
        wr(SCCR_CMD_OFF, 32'h400);
        #1;
        check({31'h0, o[4]}, 32'h0);
        wr(SCCR_CMD_OFF, 32'h0);
        evc(3'b100, 6'h10, 6'h10);
        evt(3'b000);
        $display("event test done");
    endtask
    initial begin
        presetn <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 12'h000;
        pwdata <= 32'h0;
        pstrb <= 4'h0;
        reverse_pin <= 1'b0;
        pcix_pin <= 1'b0;
        rq_set <= 8'h00;
        ev_set <= 3'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_bits;
        t_gate;
        t_split;
        t_events;
        end_of_test;
    end
endmodule
